// [logic/ofs_top.sv]
`timescale 1ns/1ps
`include "ofs_defines.svh"

// Contract
// R1: Status word packs address, constants, settings, flags
// R2: Failed CRC-8 frame check sets error flag
// R3: Voltage short sets voltage fault flag
// R4: Lost current regulation sets current fault flag
// R5: Overtemperature detector sets overtemperature flag
// R6: Software mode: any fault pulls alert low
// R7: Hardware mode: three separate fault pins
// R8: Clear input forces clear value immediately
// R9: Effective clear select is pin OR bit
// R10: Select 0 zero scale, 1 midscale
// R11: Clear release restores latest programmed setting
// R12: Clear command bit acts like clear input
// R13: Resistor select bit routes sense resistor
// R14: Status read clears packet error, releases alert
// R15: Readback drives data from 5th edge
// R16: Detector flags follow live levels, unlatched
module ofs_top
  import ofs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       link_clk,
  input  wire logic       frame_sync_n,
  input  wire logic       sdin,
  output logic            sdo_o,
  output logic            sdo_oe,
  input  wire logic [2:0] device_addr,
  input  wire logic       hw_config_select,
  input  wire logic [3:0] hw_range_code,
  input  wire logic       hw_sense_resistor_select,
  input  wire logic       clear_in,
  input  wire logic       clear_level_select,
  input  wire logic       det_vout_short,
  input  wire logic       det_current_output_open,
  input  wire logic       det_overtemp,
  output logic            fault_alert_n_o,
  output logic            fault_alert_n_oe,
  output logic            current_loop_fault_n_o,
  output logic            current_loop_fault_n_oe,
  output logic            voltage_short_fault_n_o,
  output logic            voltage_short_fault_n_oe,
  output logic            overtemp_fault_n_o,
  output logic            overtemp_fault_n_oe,
  output logic            out_clear_active,
  output logic            out_clear_midscale,
  output logic            out_enable,
  output logic [3:0]      out_range_code,
  output logic            out_ext_resistor
);

  // ------------------------------------------------------------------
  // Link domain, receive side (falling edge of the link clock)
  // ------------------------------------------------------------------
  logic           in_frame_reg;
  logic [23:0]    rx_shift_reg;
  logic [23:0]    rx_shift_next;
  logic [4:0]     rx_len_reg;
  logic [4:0]     rx_len_next;
  logic [3:0]     hdr_reg;
  logic [3:0]     hdr_next;

  // Link domain, transmit side (rising edge of the link clock)
  logic [4:0]     rise_cnt_reg;
  logic [4:0]     rise_cnt_next;
  logic [15:0]    tx_shift_reg;
  logic           sdo_reg;
  logic           sdo_oe_reg;
  logic           start_read;

  // Core domain
  logic [13:0]    pins_async;
  logic [13:0]    pins_s;
  logic           vout_short_s;
  logic           current_output_open_s;
  logic           overtemp_s;
  logic           clear_level_select_pin_s;
  logic           hw_mode_s;
  logic [2:0]     addr_s;
  logic [3:0]     hw_range_s;
  logic           hw_sense_resistor_select_s;
  logic           frame_act_s;
  logic           frame_act_d_reg;
  logic           frame_end;
  logic           sw_mode;
  logic           len16;
  logic           len24;
  logic           hdr_match;
  logic           crc_ok;
  logic [15:0]    data_word;
  ofs_frame_type  frame_kind;
  ofs_ctrl_type   ctrl_reg;
  ofs_ctrl_type   ctrl_next;
  ofs_ctrl_type   ctrl_wr;
  logic           pec_reg;
  logic           pec_next;
  ofs_status_type status_word;
  ofs_status_type snap_reg;
  ofs_status_type snap_next;
  logic           any_fault;
  logic           eff_clear_level_select;
  logic           clr_act_reg;
  logic           clr_mid_reg;
  logic           out_en_reg;
  logic [3:0]     range_reg;
  logic           ext_res_reg;
  logic           alert_oe_reg;
  logic           iflt_oe_reg;
  logic           vflt_oe_reg;
  logic           tflt_oe_reg;
  logic           od_level_reg;

  // Receive shifting: a new frame restarts the length count at one
  assign rx_len_next   = !in_frame_reg ? 5'h01 :
                         (rx_len_reg == `OFS_CNT_MAX) ? `OFS_CNT_MAX :
                         rx_len_reg + 5'h01;
  assign rx_shift_next = in_frame_reg ? {rx_shift_reg[22:0], sdin} : {23'h00_0000, sdin};
  assign hdr_next      = (in_frame_reg && rx_len_reg == `OFS_HDR_LAST) ?
                         {rx_shift_reg[2:0], sdin} : hdr_reg;

  // Frame marker, dropped at once by the frame sync going high
  always_ff @(negedge link_clk or negedge arst_n or posedge frame_sync_n) begin
    if (!arst_n) begin
      in_frame_reg <= 1'b0;
    end else if (frame_sync_n) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  // Received bits stay put after the frame so the core can take them
  always_ff @(negedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_shift_reg <= 24'h00_0000;
      rx_len_reg   <= 5'h00;
      hdr_reg      <= 4'h0;
    end else begin
      rx_shift_reg <= rx_shift_next;
      rx_len_reg   <= rx_len_next;
      hdr_reg      <= hdr_next;
    end
  end

  // Readback starts on the 5th rising edge for a matching read header
  assign rise_cnt_next = (rise_cnt_reg == `OFS_CNT_MAX) ? `OFS_CNT_MAX
                                                        : rise_cnt_reg + 5'h01;
  assign start_read    = (rise_cnt_reg == `OFS_READ_EDGE) && hdr_reg[0] &&
                         (hdr_reg[3:1] == snap_reg.device_addr); // R15

  // Serial output; tristated by the rising edge of frame sync
  always_ff @(posedge link_clk or negedge arst_n or posedge frame_sync_n) begin
    if (!arst_n) begin
      rise_cnt_reg <= 5'h00;
      tx_shift_reg <= `OFS_STATUS_RESET;
      sdo_reg      <= 1'b0;
      sdo_oe_reg   <= 1'b0;
    end else if (frame_sync_n) begin
      rise_cnt_reg <= 5'h00;
      tx_shift_reg <= `OFS_STATUS_RESET;
      sdo_reg      <= 1'b0;
      sdo_oe_reg   <= 1'b0; // R15
    end else begin
      rise_cnt_reg <= rise_cnt_next;
      if (start_read) begin
        sdo_oe_reg   <= 1'b1; // R15
        sdo_reg      <= snap_reg[15];
        tx_shift_reg <= {snap_reg[14:0], 1'b0};
      end else if (sdo_oe_reg) begin
        sdo_reg      <= tx_shift_reg[15];
        tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
      end
    end
  end

  assign sdo_o  = sdo_reg;
  assign sdo_oe = sdo_oe_reg;

  // ------------------------------------------------------------------
  // Core domain: pin synchronisers
  // ------------------------------------------------------------------
  assign pins_async = {det_vout_short, det_current_output_open, det_overtemp, clear_level_select,
                       hw_config_select, device_addr, hw_range_code,
                       hw_sense_resistor_select, ~frame_sync_n};

  ofs_sync2 #(
    .WIDTH (14)
  ) u_pin_sync (
    .clk      (ref_clk),
    .arst_n   (arst_n),
    .async_in (pins_async),
    .sync_out (pins_s)
  );

  assign vout_short_s = pins_s[13];
  assign current_output_open_s  = pins_s[12];
  assign overtemp_s   = pins_s[11];
  assign clear_level_select_pin_s = pins_s[10];
  assign hw_mode_s    = pins_s[9];
  assign addr_s       = pins_s[8:6];
  assign hw_range_s   = pins_s[5:2];
  assign hw_sense_resistor_select_s    = pins_s[1];
  assign frame_act_s  = pins_s[0];
  assign sw_mode      = !hw_mode_s;

  // Frame end: link clock is idle, so the received bits are stable
  assign frame_end = frame_act_d_reg && !frame_act_s;
  assign len16     = (rx_len_reg == `OFS_FRAME_BITS);
  assign len24     = (rx_len_reg == `OFS_PEC_FRAME_BITS);
  assign hdr_match = (hdr_reg[3:1] == addr_s);
  assign data_word = len24 ? rx_shift_reg[23:8] : rx_shift_reg[15:0];

  ofs_pec_check u_pec_check (
    .frame  (rx_shift_reg),
    .crc_ok (crc_ok)
  );

  // Frame verdict: only whole 16 or 24 bit frames for this address count
  assign frame_kind = (!frame_end || !(len16 || len24) || !hdr_match) ? OFS_FR_NONE :
                      (len24 && !crc_ok)                             ? OFS_FR_BAD  : // R2
                      hdr_reg[0]                                     ? OFS_FR_READ :
                                                                       OFS_FR_WRITE;

  // Unpack a write word into the programmed setting
  assign ctrl_wr.clear_cmd             = data_word[`OFS_WR_CLR_CMD];
  assign ctrl_wr.range_code            = data_word[`OFS_WR_RANGE_MSB:`OFS_WR_RANGE_LSB];
  assign ctrl_wr.clear_level_select    = data_word[`OFS_WR_CLEAR_LEVEL_SELECT];
  assign ctrl_wr.output_enable_bit     = data_word[`OFS_WR_OUTPUT_ENABLE_BIT];
  assign ctrl_wr.sense_resistor_select = data_word[`OFS_WR_SENSE_RESISTOR_SELECT];

  // Writes land even while clear is active, so release shows the newest value
  assign ctrl_next = (frame_kind == OFS_FR_WRITE && sw_mode) ? ctrl_wr : ctrl_reg; // R11

  // Packet error: a failed check sets it, a status read clears it; set wins
  assign pec_next = (frame_kind == OFS_FR_BAD) ||
                    (pec_reg && frame_kind != OFS_FR_READ); // R2 R14

  // Live status word; detector flags are not latched
  assign status_word.device_addr           = addr_s; // R1
  assign status_word.fixed_one             = `OFS_STAT_ONE;
  assign status_word.fixed_zero            = `OFS_STAT_ZERO;
  assign status_word.range_code            = ctrl_reg.range_code;
  assign status_word.clear_level_select    = ctrl_reg.clear_level_select;
  assign status_word.output_enable_bit     = ctrl_reg.output_enable_bit;
  assign status_word.sense_resistor_select = ctrl_reg.sense_resistor_select;
  assign status_word.packet_check_err      = pec_reg;
  assign status_word.overtemp              = overtemp_s;   // R5 R16
  assign status_word.current_output_fault  = current_output_open_s;  // R4 R16
  assign status_word.voltage_output_fault  = vout_short_s; // R3 R16

  // Snapshot frozen during a frame so the link reads a steady word
  assign snap_next = frame_act_s ? snap_reg : status_word; // R1

  assign any_fault  = current_output_open_s || vout_short_s || pec_reg || overtemp_s; // R6
  assign eff_clear_level_select = clear_level_select_pin_s || (sw_mode && ctrl_reg.clear_level_select); // R9

  // Core state registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_act_d_reg <= 1'b0;
      ctrl_reg        <= `OFS_CTRL_RESET;
      pec_reg         <= `OFS_PEC_RESET;
      snap_reg        <= `OFS_STATUS_RESET;
    end else begin
      frame_act_d_reg <= frame_act_s;
      ctrl_reg        <= ctrl_next;
      pec_reg         <= pec_next;
      snap_reg        <= snap_next;
    end
  end

  // Clear force: the pin sets it without a clock edge, the command bit via the clock
  always_ff @(posedge ref_clk or negedge arst_n or posedge clear_in) begin
    if (!arst_n) begin
      clr_act_reg <= 1'b0;
    end else if (clear_in) begin
      clr_act_reg <= 1'b1; // R8
    end else begin
      clr_act_reg <= sw_mode && ctrl_reg.clear_cmd; // R11 R12
    end
  end

  // Output stage steering; hardware mode takes range and resistor from pins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clr_mid_reg <= 1'b0;
      out_en_reg  <= 1'b0;
      range_reg   <= 4'h0;
      ext_res_reg <= 1'b0;
    end else begin
      clr_mid_reg <= eff_clear_level_select; // R10
      out_en_reg  <= sw_mode ? ctrl_reg.output_enable_bit : 1'b1;
      range_reg   <= sw_mode ? ctrl_reg.range_code : hw_range_s;
      ext_res_reg <= sw_mode ? ctrl_reg.sense_resistor_select : hw_sense_resistor_select_s; // R13
    end
  end

  // Open-drain fault pins: enable high pulls the pin low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alert_oe_reg <= 1'b0;
      iflt_oe_reg  <= 1'b0;
      vflt_oe_reg  <= 1'b0;
      tflt_oe_reg  <= 1'b0;
      od_level_reg <= 1'b0;
    end else begin
      alert_oe_reg <= sw_mode && any_fault;      // R6 R14
      iflt_oe_reg  <= hw_mode_s && current_output_open_s;  // R7
      vflt_oe_reg  <= hw_mode_s && vout_short_s; // R7
      tflt_oe_reg  <= hw_mode_s && overtemp_s;   // R7
      od_level_reg <= 1'b0;
    end
  end

  assign fault_alert_n_o          = od_level_reg;
  assign fault_alert_n_oe         = alert_oe_reg;
  assign current_loop_fault_n_o   = od_level_reg;
  assign current_loop_fault_n_oe  = iflt_oe_reg;
  assign voltage_short_fault_n_o  = od_level_reg;
  assign voltage_short_fault_n_oe = vflt_oe_reg;
  assign overtemp_fault_n_o       = od_level_reg;
  assign overtemp_fault_n_oe      = tflt_oe_reg;
  assign out_clear_active         = clr_act_reg;
  assign out_clear_midscale       = clr_mid_reg;
  assign out_enable               = out_en_reg;
  assign out_range_code           = range_reg;
  assign out_ext_resistor         = ext_res_reg;

endmodule

// [logic/ofs_defines.svh]
`ifndef OFS_DEFINES_SVH
`define OFS_DEFINES_SVH

// Serial frame lengths, in bits
`define OFS_FRAME_BITS      5'h10
`define OFS_PEC_FRAME_BITS  5'h18
`define OFS_CNT_MAX         5'h1F
// Bits already shifted when the fourth header bit arrives
`define OFS_HDR_LAST        5'h03
// Rising edges already seen when the 5th rising edge starts readback
`define OFS_READ_EDGE       5'h04

// Write word fields
`define OFS_WR_ADDR_MSB     15
`define OFS_WR_ADDR_LSB     13
`define OFS_WR_RW           12
`define OFS_WR_CLR_CMD      11
`define OFS_WR_RANGE_MSB    10
`define OFS_WR_RANGE_LSB    7
`define OFS_WR_CLEAR_LEVEL_SELECT       6
`define OFS_WR_OUTPUT_ENABLE_BIT        5
`define OFS_WR_SENSE_RESISTOR_SELECT         4

// Status word constants and reset values
`define OFS_STAT_ONE        1'h1
`define OFS_STAT_ZERO       1'h0
`define OFS_CTRL_RESET      8'h00
`define OFS_PEC_RESET       1'h0
`define OFS_STATUS_RESET    16'h0000

// Packet check polynomial x8 + x2 + x1 + 1
`define OFS_CRC_POLY        8'h07
`define OFS_CRC_INIT        8'h00

`endif

// [logic/ofs_pkg.sv]
`include "ofs_defines.svh"

package ofs_pkg;

  // Programmed setting held by the device
  typedef struct packed {
    logic       clear_cmd;
    logic [3:0] range_code;
    logic       clear_level_select;
    logic       output_enable_bit;
    logic       sense_resistor_select;
  } ofs_ctrl_type;

  // Readback status word, D15 first
  typedef struct packed {
    logic [2:0] device_addr;
    logic       fixed_one;
    logic       fixed_zero;
    logic [3:0] range_code;
    logic       clear_level_select;
    logic       output_enable_bit;
    logic       sense_resistor_select;
    logic       packet_check_err;
    logic       overtemp;
    logic       current_output_fault;
    logic       voltage_output_fault;
  } ofs_status_type;

  // Verdict on a finished frame
  typedef enum logic [1:0] {
    OFS_FR_NONE  = 2'b00,
    OFS_FR_WRITE = 2'b01,
    OFS_FR_READ  = 2'b10,
    OFS_FR_BAD   = 2'b11
  } ofs_frame_type;

endpackage

// [logic/ofs_sync2.sv]
`timescale 1ns/1ps

module ofs_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // Two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// [logic/ofs_pec_check.sv]
`timescale 1ns/1ps
`include "ofs_defines.svh"

module ofs_pec_check
  import ofs_pkg::*;
(
  input  wire logic [23:0] frame,
  output logic             crc_ok
);

  logic [7:0] crc;

  // CRC-8 over the 16 data bits, MSB first, compared with the trailing byte
  always_comb begin
    crc = `OFS_CRC_INIT;
    for (int i = 23; i >= 8; i--) begin
      if (crc[7] ^ frame[i]) begin
        crc = {crc[6:0], 1'b0} ^ `OFS_CRC_POLY;
      end else begin
        crc = {crc[6:0], 1'b0};
      end
    end
    crc_ok = (crc == frame[7:0]);
  end

endmodule

// [sim/ofs_monitor.sv]
`timescale 1ns/1ps

module ofs_monitor
  import ofs_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       link_clk,
  input wire logic       frame_sync_n,
  input wire logic       sdo_oe,
  input wire logic       hw_config_select,
  input wire logic       clear_in,
  input wire logic       clear_level_select,
  input wire logic       det_vout_short,
  input wire logic       det_current_output_open,
  input wire logic       det_overtemp,
  input wire logic       fault_alert_n_oe,
  input wire logic       current_loop_fault_n_oe,
  input wire logic       voltage_short_fault_n_oe,
  input wire logic       overtemp_fault_n_oe,
  input wire logic       out_clear_active,
  input wire logic       out_clear_midscale,
  input wire logic [3:0] out_range_code,
  input wire logic       out_ext_resistor
);
  // Serial output released between frames, silent for the first four edges
  a_sdo_release: assert property (
    @(posedge ref_clk) disable iff (!arst_n) frame_sync_n && $past(frame_sync_n) |-> !sdo_oe)
    else $error("sdo driven between frames");
  // Rising link edges seen in the current frame, cleared while the frame is idle
  logic [4:0] link_edge_cnt;
  always_ff @(posedge link_clk or posedge frame_sync_n) begin
    if (frame_sync_n) begin
      link_edge_cnt <= 5'h00;
    end else if (link_edge_cnt != 5'h1F) begin
      link_edge_cnt <= link_edge_cnt + 5'h01;
    end
  end
  a_sdo_late_start: assert property (
    @(posedge link_clk) disable iff (!arst_n) link_edge_cnt < 5'h05 |-> !sdo_oe)
    else $error("sdo driven before fifth edge");
  // Fault outputs follow their detectors
  a_alert_sw_fault: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $rose(det_vout_short) && !hw_config_select |-> ##[1:4] fault_alert_n_oe)
    else $error("alert not pulled low");
  a_vshort_hw_pin: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $rose(det_vout_short) && hw_config_select |-> ##[1:4] voltage_short_fault_n_oe)
    else $error("voltage short pin idle");
  a_iopen_hw_pin: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $rose(det_current_output_open) && hw_config_select |-> ##[1:4] current_loop_fault_n_oe)
    else $error("current loop pin idle");
  a_otemp_hw_pin: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $rose(det_overtemp) && hw_config_select |-> ##[1:4] overtemp_fault_n_oe)
    else $error("overtemperature pin idle");
  a_alert_hw_off: assert property (
    @(posedge ref_clk) disable iff (!arst_n) hw_config_select [*6] |-> !fault_alert_n_oe)
    else $error("alert driven in hardware mode");
  // Clear behaviour and setting hold inside a frame
  a_clear_level_select_pin_or: assert property (
    @(posedge ref_clk) disable iff (!arst_n) clear_level_select [*5] |-> out_clear_midscale)
    else $error("clear select pin ignored");
  a_clear_force: assert property (
    @(posedge ref_clk) disable iff (!arst_n) clear_in && $past(clear_in) |-> out_clear_active)
    else $error("clear not forced");
  a_write_hold: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !frame_sync_n [*8] |-> $stable(out_range_code) && $stable(out_ext_resistor))
    else $error("setting changed inside frame");
  // Main scenarios reached
  c_read: cover property (@(posedge ref_clk) $rose(sdo_oe));
  c_clear: cover property (@(posedge ref_clk) $rose(out_clear_active));
  c_vshort: cover property (@(posedge ref_clk) $rose(voltage_short_fault_n_oe));
endmodule

bind ofs_top ofs_monitor ofs_monitor_inst (
  .ref_clk(ref_clk), .arst_n(arst_n), .link_clk(link_clk), .frame_sync_n(frame_sync_n),
  .sdo_oe(sdo_oe), .hw_config_select(hw_config_select), .clear_in(clear_in),
  .clear_level_select(clear_level_select), .det_vout_short(det_vout_short),
  .det_current_output_open(det_current_output_open), .det_overtemp(det_overtemp),
  .fault_alert_n_oe(fault_alert_n_oe), .current_loop_fault_n_oe(current_loop_fault_n_oe),
  .voltage_short_fault_n_oe(voltage_short_fault_n_oe),
  .overtemp_fault_n_oe(overtemp_fault_n_oe), .out_clear_active(out_clear_active),
  .out_clear_midscale(out_clear_midscale), .out_range_code(out_range_code),
  .out_ext_resistor(out_ext_resistor));

// [sim/ofs_host_model.sv]
`timescale 1ns/1ps

module ofs_host_model (
  output logic     link_clk,
  output logic     frame_sync_n,
  output logic     sdin,
  input wire logic sdo_line
);
  // Idle link: clock parked, frame select high
  initial begin
    link_clk = 1'b0;
    frame_sync_n = 1'b1;
    sdin = 1'b0;
  end

  // Frame check sequence over the data bits, MSB first
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  // One frame of n bits; bad corrupts the check byte; rd collects readback
  task automatic xfer(input logic [15:0] w, input int n, input logic bad,
                      output logic [15:0] rd);
    logic [23:0] f;
    f = {w, crc8(w) ^ {7'h00, bad}};
    rd = 16'h0000;
    #3 frame_sync_n = 1'b0;
    #80;  // Settle time before the first rising edge
    for (int i = 0; i < n; i++) begin
      #1 sdin = f[23-i];
      #5 link_clk = 1'b1;
      #6;
      if (i > 3 && i < 20) rd[19-i] = sdo_line;
      link_clk = 1'b0;
    end
    #1 sdin = ~sdin;
    frame_sync_n = 1'b1;
    #120;
  endtask
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
  import ofs_pkg::*;
  logic       ref_clk, arst_n, link_clk, frame_sync_n, sdin, sdo_o, sdo_oe, sdo_line;
  logic       sdo_last, hw_config_select, hw_sense_resistor_select, clear_in;
  logic       clear_level_select, det_vout_short, det_current_output_open, det_overtemp;
  logic       fault_alert_n_oe, current_loop_fault_n_oe, voltage_short_fault_n_oe;
  logic       overtemp_fault_n_oe, out_clear_active, out_clear_midscale, out_enable;
  logic       out_ext_resistor;
  logic [2:0] device_addr;
  logic [3:0] hw_range_code, out_range_code;
  logic [15:0] rd;
  logic [3:0] od_lvl;
  int         miscompares, checked, m_rng, m_sel, m_rs, m_pec, seed, r;

  ofs_top ofs_top_inst (.ref_clk(ref_clk), .arst_n(arst_n), .link_clk(link_clk),
    .frame_sync_n(frame_sync_n), .sdin(sdin), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .device_addr(device_addr), .hw_config_select(hw_config_select),
    .hw_range_code(hw_range_code), .hw_sense_resistor_select(hw_sense_resistor_select),
    .clear_in(clear_in), .clear_level_select(clear_level_select),
    .det_vout_short(det_vout_short), .det_current_output_open(det_current_output_open),
    .det_overtemp(det_overtemp), .fault_alert_n_o(od_lvl[0]), .fault_alert_n_oe(fault_alert_n_oe),
    .current_loop_fault_n_o(od_lvl[1]), .current_loop_fault_n_oe(current_loop_fault_n_oe),
    .voltage_short_fault_n_o(od_lvl[2]), .voltage_short_fault_n_oe(voltage_short_fault_n_oe),
    .overtemp_fault_n_o(od_lvl[3]), .overtemp_fault_n_oe(overtemp_fault_n_oe),
    .out_clear_active(out_clear_active), .out_clear_midscale(out_clear_midscale),
    .out_enable(out_enable), .out_range_code(out_range_code),
    .out_ext_resistor(out_ext_resistor));
  ofs_host_model ofs_host_model_inst (.link_clk(link_clk), .frame_sync_n(frame_sync_n),
    .sdin(sdin), .sdo_line(sdo_line));

  // Released serial output shows the inverse of its last bit
  assign sdo_line = sdo_oe ? sdo_o : ~sdo_last;
  always @(posedge link_clk) if (sdo_oe) sdo_last <= sdo_o;
  // Core clock
  always #10 ref_clk = ~ref_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Write frame; the model follows only in software mode
  task automatic wr(input logic [3:0] rg, input logic sl, input logic rs, input logic cl);
    ofs_host_model_inst.xfer({device_addr, 1'b0, cl, rg, sl, 1'b1, rs, 4'h0}, 16, 1'b0, rd);
    wt(8);
    if (!hw_config_select) begin
      m_rng = rg;
      m_sel = sl;
      m_rs = rs;
    end
  endtask

  // Checked readback; a whole read clears the packet error
  task automatic rdst;
    ofs_host_model_inst.xfer({device_addr, 1'b1, 12'h000}, 24, 1'b0, rd);
    check(rd, {device_addr, 2'b10, m_rng[3:0], m_sel[0], 1'b1, m_rs[0], m_pec[0],
      det_overtemp, det_current_output_open, det_vout_short});
    m_pec = 0;
    wt(8);
  endtask

  // Raise each detector alone, then drop it again
  task automatic det_scan;
    for (int i = 0; i < 3; i++) begin
      {det_overtemp, det_current_output_open, det_vout_short} <= 3'b001 << i;
      wt(6);
      if (hw_config_select) begin
        check({current_loop_fault_n_oe, voltage_short_fault_n_oe, overtemp_fault_n_oe,
          fault_alert_n_oe}, {det_current_output_open, det_vout_short, det_overtemp, 1'b0});
      end else begin
        check(fault_alert_n_oe, 1'b1);
        rdst();
      end
      {det_overtemp, det_current_output_open, det_vout_short} <= 3'b000;
      wt(6);
      check({current_loop_fault_n_oe, voltage_short_fault_n_oe, overtemp_fault_n_oe,
        fault_alert_n_oe}, 16'h0000);
      check(od_lvl, 4'h0);
    end
  endtask

  // Main sequence
  initial begin
    {ref_clk, arst_n, sdo_last, hw_config_select, clear_in, clear_level_select} = 6'h00;
    {det_vout_short, det_current_output_open, det_overtemp} = 3'h0;
    seed = 32'hb683_c646;
    r = $random(seed);
    device_addr <= r[2:0];
    hw_range_code <= r[6:3];
    hw_sense_resistor_select <= r[7];
    {m_rng, m_sel, m_rs, m_pec, miscompares, checked} = '0;
    wt(10);
    check({sdo_oe, fault_alert_n_oe, out_clear_active, out_enable, out_range_code}, 0);
    arst_n <= 1'b1;
    wt(6);
    repeat (3) begin
      r = $random(seed);
      wr(r[3:0], 1'b0, r[4], 1'b0);
      check({out_enable, out_range_code, out_ext_resistor}, {1'b1, m_rng[3:0], m_rs[0]});
      rdst();
    end
    ofs_host_model_inst.xfer({~device_addr, 1'b0, 1'b0, ~m_rng[3:0], 7'h00}, 16, 1'b0, rd);
    ofs_host_model_inst.xfer({device_addr, 1'b0, 1'b0, ~m_rng[3:0], 7'h00}, 24, 1'b1, rd);
    wt(8);
    m_pec = 1;
    check(out_range_code, m_rng[3:0]);
    check(fault_alert_n_oe, 1'b1);
    rdst();
    check(fault_alert_n_oe, 1'b0);
    det_scan();
    for (int k = 0; k < 4; k++) begin
      clear_level_select <= k[0];
      wr(m_rng[3:0], k[1], m_rs[0], 1'b0);
      check(out_clear_midscale, k[0] | k[1]);
    end
    clear_in <= 1'b1;
    @(posedge ref_clk);
    #1 check(out_clear_active, 1'b1);
    wr(~m_rng[3:0], 1'b0, m_rs[0], 1'b0);
    check(out_clear_active, 1'b1);
    clear_in <= 1'b0;
    wt(3);
    check({out_clear_active, out_range_code}, {1'b0, m_rng[3:0]});
    wr(m_rng[3:0], 1'b0, m_rs[0], 1'b1);
    check(out_clear_active, 1'b1);
    wr(m_rng[3:0], 1'b0, m_rs[0], 1'b0);
    check(out_clear_active, 1'b0);
    hw_config_select <= 1'b1;
    wt(8);
    wr(~hw_range_code, 1'b0, ~hw_sense_resistor_select, 1'b0);
    check({out_enable, out_range_code, out_ext_resistor},
      {1'b1, hw_range_code, hw_sense_resistor_select});
    det_scan();
    complete_run();
  end

  // Watchdog against a hung run
  initial begin
    #400_000;
    miscompares++;
    complete_run();
  end
endmodule
